// [rtl/flash_ctrl_pkg.sv]
// Shared constants and types for the nonvolatile array program and erase control.
`default_nettype none

package flash_ctrl_pkg;

  // ==========================================================================
  // Bus and array geometry
  // ==========================================================================
  localparam int          APB_ADDR_W   = 18;
  localparam int          APB_DATA_W   = 32;
  localparam int          ARRAY_ADDR_W = 14;
  localparam int          ERASE_CNT_W  = 15;
  localparam int          ARRAY_BYTES  = 16384;
  localparam int          PAGE_BYTES   = 64;
  localparam int          ROW_BYTES    = 32;
  localparam int          PAGE_LSB     = 6;
  localparam int          ROW_LSB      = 5;

  // ==========================================================================
  // Register indices (byte address on the bus is four times the index)
  // ==========================================================================
  localparam logic [15:0] ARRAY_CONTROL_IDX = 16'hfe08;
  localparam logic [15:0] PROTECT_START_IDX = 16'hff7e;
  localparam logic [1:0]  ARRAY_TOP_BITS    = 2'b11;

  // ==========================================================================
  // Values
  // ==========================================================================
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [7:0]  PROTECT_OPEN = 8'hff;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic       fail;
    logic [2:0] spare;
    logic       highVoltageEnable;
    logic       mass;
    logic       erase;
    logic       programSelect;
  } ctrl_type;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_ARMED   = 5'b00010,
    ST_CHECKED = 5'b00100,
    ST_LATCHED = 5'b01000,
    ST_HV      = 5'b10000
  } stage_type;

endpackage

`default_nettype wire

// [rtl/flash_erase_walker.sv]
// Address sweeper that steps one byte address per cycle over a page or the array.
`timescale 1ns/100ps
`default_nettype none

module flash_erase_walker #(
  parameter int ADDR_W = 14,
  parameter int CNT_W  = 15
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] base,
  input  wire logic [CNT_W-1:0]  count,
  output logic                   busy,
  output logic [ADDR_W-1:0]      addr
);

  logic [CNT_W-1:0]  leftFf;
  logic [ADDR_W-1:0] addrFf;

  // ==========================================================================
  // Sweep
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      leftFf <= '0;
      addrFf <= '0;
    end else if (start) begin
      leftFf <= count;
      addrFf <= base;
    end else if (leftFf != '0) begin
      leftFf <= leftFf - CNT_W'(1);
      addrFf <= addrFf + ADDR_W'(1);
    end
  end

  assign busy = (leftFf != '0);
  assign addr = addrFf;

endmodule

`default_nettype wire

// [rtl/flash_program_erase_control.sv]
// APB-reached program and erase sequencer with block protection for a 16-Kbyte array.
`timescale 1ns/100ps
`default_nettype none

module flash_program_erase_control (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [flash_ctrl_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [flash_ctrl_pkg::APB_DATA_W-1:0] pwdata,
  input  wire logic                                  testHighVoltage,
  output logic [flash_ctrl_pkg::APB_DATA_W-1:0]      prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  output logic                                       highVoltageOn
);
  import flash_ctrl_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Storage and state
  // ==========================================================================
  // The array keeps its contents through reset, like the cells it models.
  logic [7:0]              memArr [ARRAY_BYTES];
  ctrl_type                ctrl_ff;
  ctrl_type                nxt_ctrl;
  stage_type               stage_ff;
  stage_type               nxt_stage;
  logic [ARRAY_ADDR_W-1:0] target_ff;
  logic                    massOp_ff;
  logic [31:0]             rdata_ff;
  logic                    slverr_ff;
  logic                    fresh_ff;
  logic                    first_ff;

  logic [15:0]             idx;
  logic [ARRAY_ADDR_W-1:0] arrIdx;
  logic                    inArray;
  logic                    isCtrl;
  logic                    isProt;
  logic                    goodAddr;
  logic                    eraseBusy;
  logic [ARRAY_ADDR_W-1:0] eraseAddr;
  logic                    eraseStart;
  logic [ARRAY_ADDR_W-1:0] eraseBase;
  logic [ERASE_CNT_W-1:0]  eraseCount;
  logic                    doAccess;
  logic                    ctrlWrite;
  logic                    arrWrite;
  logic                    protRead;
  logic                    progWrite;
  logic                    progOk;
  logic [7:0]              protBits;
  logic                    massOk;
  logic                    hvAllowed;
  ctrl_type                wCtrl;

  initial begin
    for (int i = 0; i < ARRAY_BYTES; i++) begin
      memArr[i] = ERASED_BYTE;
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Start of the protected block: top two bits one, protect bits, six zero bits.
  function automatic logic isProtected(input logic [7:0] bits, input logic bypass,
                                       input logic [ARRAY_ADDR_W-1:0] a);
    logic [15:0] startAddr;
    startAddr = {ARRAY_TOP_BITS, bits, 6'h00};
    isProtected = !bypass && (bits != PROTECT_OPEN)
                  && ({ARRAY_TOP_BITS, a} >= startAddr);
  endfunction

  function automatic logic sameRow(input logic [ARRAY_ADDR_W-1:0] a,
                                   input logic [ARRAY_ADDR_W-1:0] b);
    sameRow = (a[ARRAY_ADDR_W-1:ROW_LSB] == b[ARRAY_ADDR_W-1:ROW_LSB]);
  endfunction

  // ==========================================================================
  // Address decode
  // ==========================================================================
  assign idx      = paddr[17:2];
  assign arrIdx   = idx[ARRAY_ADDR_W-1:0];
  assign inArray  = (idx[15:14] == ARRAY_TOP_BITS) && !isCtrl;
  assign isCtrl   = (idx == ARRAY_CONTROL_IDX);
  assign isProt   = (idx == PROTECT_START_IDX);
  assign goodAddr = (paddr[1:0] == 2'b00) && (idx[15:14] == ARRAY_TOP_BITS);
  assign protBits = memArr[PROTECT_START_IDX[ARRAY_ADDR_W-1:0]];

  // The answer is held back while an erase sweep owns the array, and for one
  // cycle after, so that read data never comes from a half-erased page.
  assign pready   = penable && !eraseBusy && fresh_ff;
  assign doAccess = psel && penable && pready;
  assign ctrlWrite = doAccess && pwrite && isCtrl && goodAddr;
  assign arrWrite  = doAccess && pwrite && inArray && goodAddr;
  assign protRead  = doAccess && !pwrite && isProt && goodAddr;
  assign wCtrl     = ctrl_type'(pwdata[7:0]);

  // ==========================================================================
  // Read data and error capture
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff  <= '0;
      slverr_ff <= 1'b0;
      fresh_ff  <= 1'b0;
    end else if (psel && !doAccess) begin
      fresh_ff  <= !eraseBusy;
      slverr_ff <= !goodAddr;
      if (!goodAddr) begin
        rdata_ff <= '0;
      end else if (isCtrl) begin
        rdata_ff <= {24'h000000, ctrl_ff};
      end else begin
        rdata_ff <= {24'h000000, memArr[arrIdx]};
      end
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  assign prdata  = rdata_ff;
  assign pslverr = slverr_ff && pready;

  // ==========================================================================
  // Control bits and sequence stage
  // ==========================================================================
  assign massOk = (protBits == PROTECT_OPEN) || testHighVoltage;
  assign hvAllowed = (stage_ff == ST_LATCHED) && (ctrl_ff.programSelect ^ ctrl_ff.erase)
                     && !isProtected(protBits, testHighVoltage, target_ff)
                     && !(ctrl_ff.erase && ctrl_ff.mass && !massOk);

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_stage = stage_ff;
    if (ctrlWrite) begin
      nxt_ctrl.mass = wCtrl.mass;
      // A write asking for both operations leaves both as they were.
      if (!(wCtrl.programSelect && wCtrl.erase)) begin
        nxt_ctrl.programSelect = wCtrl.programSelect;
        nxt_ctrl.erase         = wCtrl.erase;
      end
      // High voltage only comes on in a write that keeps the operation bits as
      // they are, since the checks above vetted the operation already selected.
      if (!wCtrl.highVoltageEnable) begin
        nxt_ctrl.highVoltageEnable = 1'b0;
      end else if (!ctrl_ff.highVoltageEnable && hvAllowed
                   && (nxt_ctrl == ctrl_ff)) begin
        nxt_ctrl.highVoltageEnable = 1'b1;
        nxt_stage                  = ST_HV;
      end
      if ({nxt_ctrl.programSelect, nxt_ctrl.erase}
          != {ctrl_ff.programSelect, ctrl_ff.erase}) begin
        nxt_stage = (nxt_ctrl.programSelect || nxt_ctrl.erase) ? ST_ARMED : ST_IDLE;
      end
      if (nxt_ctrl.programSelect && !ctrl_ff.programSelect) begin
        nxt_ctrl.fail = 1'b0;
      end
    end else if (protRead && stage_ff == ST_ARMED) begin
      nxt_stage = ST_CHECKED;
    end else if (arrWrite && stage_ff == ST_CHECKED) begin
      nxt_stage = ST_LATCHED;
    end
    // A row fault sets the flag regardless of the control write above.
    if (progWrite && !progOk) begin
      nxt_ctrl.fail = 1'b1;
    end
    nxt_ctrl.spare = 3'b000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff  <= ctrl_type'(CTRL_RESET);
      stage_ff <= ST_IDLE;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      stage_ff <= nxt_stage;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_ff <= '0;
      massOp_ff <= 1'b0;
    end else begin
      if (arrWrite && stage_ff == ST_CHECKED) begin
        target_ff <= arrIdx;
      end
      if (ctrlWrite && nxt_stage == ST_HV && stage_ff != ST_HV) begin
        massOp_ff <= ctrl_ff.mass;
      end
    end
  end

  assign highVoltageOn = ctrl_ff.highVoltageEnable;

  // ==========================================================================
  // Programming and erasing
  // ==========================================================================
  assign progWrite = arrWrite && stage_ff == ST_HV
                     && ctrl_ff.programSelect && ctrl_ff.highVoltageEnable;
  assign progOk    = sameRow(arrIdx, target_ff)
                     && !isProtected(protBits, testHighVoltage, arrIdx);

  // The erase lands when erase is cleared under high voltage, ending the pulse.
  assign eraseStart = ctrlWrite && stage_ff == ST_HV && ctrl_ff.erase
                      && ctrl_ff.highVoltageEnable && !nxt_ctrl.erase;
  assign eraseBase  = massOp_ff ? '0 : {target_ff[ARRAY_ADDR_W-1:PAGE_LSB], 6'h00};
  assign eraseCount = massOp_ff ? ERASE_CNT_W'(ARRAY_BYTES)
                                : ERASE_CNT_W'(PAGE_BYTES);

  flash_erase_walker #(
    .ADDR_W (ARRAY_ADDR_W),
    .CNT_W  (ERASE_CNT_W)
  ) u_walker (
    .clk   (clk),
    .rst_n (rst_n),
    .start (eraseStart),
    .base  (eraseBase),
    .count (eraseCount),
    .busy  (eraseBusy),
    .addr  (eraseAddr)
  );

  // Programming only clears bits, so an erased one can become a zero. Any page,
  // the protect-start byte's own among them, is swept to ones by an erase.
  // A plain clocked process, because the factory fill above writes the array too.
  always @(posedge clk) begin
    if (eraseBusy) begin
      memArr[eraseAddr] <= ERASED_BYTE;
    end else if (progWrite && progOk) begin
      memArr[arrIdx] <= memArr[arrIdx] & pwdata[7:0];
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  // Counts the cycles of a sweep, so that a whole-array erase can be measured
  // without a repetition thousands of cycles long.
  logic [ERASE_CNT_W-1:0] sweepLen_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sweepLen_ff <= '0;
    end else if (eraseStart) begin
      sweepLen_ff <= '0;
    end else if (eraseBusy) begin
      sweepLen_ff <= sweepLen_ff + ERASE_CNT_W'(1);
    end
  end

  chk_ops_interlock: assert property (!(ctrl_ff.programSelect && ctrl_ff.erase))
    else $error("program and erase both set");
  chk_both_refused: assert property (ctrlWrite && wCtrl.programSelect && wCtrl.erase
      |=> ctrl_ff.programSelect == $past(ctrl_ff.programSelect)
          && ctrl_ff.erase == $past(ctrl_ff.erase))
    else $error("write asking for both operations took effect");
  chk_stage_onehot: assert property ($onehot(stage_ff))
    else $error("sequence stage is not one-hot");
  chk_hv_sequence: assert property ($rose(ctrl_ff.highVoltageEnable)
      |-> $past(stage_ff) == ST_LATCHED)
    else $error("high voltage set outside latched stage");
  chk_hv_one_op: assert property ($rose(ctrl_ff.highVoltageEnable)
      |-> ctrl_ff.programSelect ^ ctrl_ff.erase)
    else $error("high voltage set without exactly one operation");
  chk_mass_guard: assert property ($rose(ctrl_ff.highVoltageEnable) && ctrl_ff.erase
      && ctrl_ff.mass |-> $past(protBits) == PROTECT_OPEN || $past(testHighVoltage))
    else $error("mass erase armed while a block is protected");
  chk_protect_target: assert property ($rose(ctrl_ff.highVoltageEnable)
      |-> !isProtected($past(protBits), $past(testHighVoltage), target_ff))
    else $error("high voltage set for a protected target");
  chk_protected_kept: assert property (arrWrite
      && isProtected(protBits, testHighVoltage, arrIdx)
      |=> memArr[$past(arrIdx)] == $past(memArr[arrIdx]))
    else $error("protected byte changed by a write");
  chk_row_fault: assert property (progWrite && !progOk |=> ctrl_ff.fail)
    else $error("row fault not flagged");
  chk_fail_sticky: assert property (ctrl_ff.fail && !(ctrlWrite && wCtrl.programSelect
      && !wCtrl.erase && !ctrl_ff.programSelect) |=> ctrl_ff.fail)
    else $error("row fault flag lost before a new program cycle");
  chk_page_base: assert property (eraseStart && !massOp_ff
      |=> eraseAddr[PAGE_LSB-1:0] == '0)
    else $error("page erase does not start on a page boundary");
  chk_mass_from_zero: assert property (eraseStart && massOp_ff |=> eraseAddr == '0)
    else $error("mass erase does not start at the array base");
  chk_mass_length: assert property ($fell(eraseBusy) && massOp_ff
      |-> sweepLen_ff == ERASE_CNT_W'(ARRAY_BYTES))
    else $error("mass erase does not span the whole array");
  chk_erase_fills: assert property (eraseBusy |=> memArr[$past(eraseAddr)] == ERASED_BYTE)
    else $error("swept byte does not read as erased");
  chk_busy_stall: assert property (eraseBusy |-> !pready)
    else $error("bus answered during an erase sweep");
  chk_page_length: assert property (eraseStart && !massOp_ff
      |-> ##1 eraseBusy ##63 eraseBusy ##1 !eraseBusy)
    else $error("page erase does not span 64 bytes");
  chk_program_and: assert property (progWrite && progOk
      |=> memArr[$past(arrIdx)] == ($past(memArr[arrIdx]) & $past(pwdata[7:0])))
    else $error("programmed byte is not the and of old and new");
  chk_reset_clear: assert property (first_ff |-> ctrl_ff == ctrl_type'(CTRL_RESET))
    else $error("control bits not clear after reset");

  cov_page_erase: cover property (eraseStart && !massOp_ff);
  cov_mass_erase: cover property (eraseStart && massOp_ff);
  cov_program_ok: cover property (progWrite && progOk);
  cov_row_fault:  cover property (progWrite && !progOk);
  cov_bypass_hv:  cover property ($rose(ctrl_ff.highVoltageEnable) && testHighVoltage);

endmodule

`default_nettype wire

// [test/cpu_sw_model.sv]
// CPU software model: bus master plus the program and erase sequences.
`timescale 1ns/100ps
`default_nettype none

module cpu_sw_model (
  input  wire logic                                  clk,
  input  wire logic [flash_ctrl_pkg::APB_DATA_W-1:0] prdata,
  input  wire logic                                  pready,
  input  wire logic                                  pslverr,
  output logic                                       psel,
  output logic                                       penable,
  output logic                                       pwrite,
  output logic [flash_ctrl_pkg::APB_ADDR_W-1:0]      paddr,
  output logic [flash_ctrl_pkg::APB_DATA_W-1:0]      pwdata
);
  import flash_ctrl_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // ==========================================================================
  // Bus transfer
  // ==========================================================================
  // The wait for pready is open-ended; a mass erase sweep holds it off, and
  // the bench watchdog ends a wait that never finishes.
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    access(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [7:0] d);
    logic e;
    access(1'b0, idx, 8'h00, d, e);
  endtask

  // ==========================================================================
  // Sequences
  // ==========================================================================
  // Delays between steps are not modelled; the hardware does not time them.
  // Two data writes are made so that a caller can cross a row on purpose.
  task automatic programByte(input logic [15:0] idx, input logic [7:0] d,
                             input logic [15:0] idx2, output logic [7:0] hvSeen,
                             output logic [7:0] endSeen);
    logic [7:0] t;
    wr(ARRAY_CONTROL_IDX, 8'h01);
    rd(PROTECT_START_IDX, t);
    wr(idx, 8'hff);
    wr(ARRAY_CONTROL_IDX, 8'h09);
    rd(ARRAY_CONTROL_IDX, hvSeen);
    wr(idx, d);
    wr(idx2, d);
    wr(ARRAY_CONTROL_IDX, 8'h08);
    wr(ARRAY_CONTROL_IDX, 8'h00);
    rd(ARRAY_CONTROL_IDX, endSeen);
  endtask

  task automatic eraseOp(input logic mass, input logic [15:0] idx,
                         output logic [7:0] hvSeen);
    logic [7:0] t;
    wr(ARRAY_CONTROL_IDX, {5'b00000, mass, 2'b10});
    rd(PROTECT_START_IDX, t);
    wr(idx, 8'h00);
    wr(ARRAY_CONTROL_IDX, {4'b0000, 1'b1, mass, 2'b10});
    rd(ARRAY_CONTROL_IDX, hvSeen);
    wr(ARRAY_CONTROL_IDX, 8'h08);
    wr(ARRAY_CONTROL_IDX, 8'h00);
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the program and erase sequencer.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import flash_ctrl_pkg::*;

  logic                  clk;
  logic                  rst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [APB_ADDR_W-1:0] paddr;
  logic [APB_DATA_W-1:0] pwdata;
  logic                  testHighVoltage;
  logic [APB_DATA_W-1:0] prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  highVoltageOn;
  logic [7:0]            v;
  logic [7:0]            fin;
  logic                  e;
  logic                  hvWasOn;
  int                    numErrors;
  int                    checksDone;

  flash_program_erase_control DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .testHighVoltage(testHighVoltage),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .highVoltageOn(highVoltageOn)
  );

  cpu_sw_model cpu (
    .clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Sticky record that the high-voltage output came on during the run.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hvWasOn <= 1'b0;
    end else if (highVoltageOn === 1'b1) begin
      hvWasOn <= 1'b1;
    end
  end

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      numErrors++;
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One mass erase sweep of about 16k cycles dominates the run; the limit leaves wide room.
  initial begin
    repeat (90000) @(posedge clk);
    numErrors++;
    summarize();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    numErrors = 0;
    checksDone = 0;
    rst_n = 1'b0;
    testHighVoltage = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cpu.rd(ARRAY_CONTROL_IDX, v);
    check("ctrl reset", 8'h00, v);
    cpu.rd(PROTECT_START_IDX, v);
    check("protect erased", 8'hff, v);
    cpu.rd(16'hc000, v);
    check("array erased", 8'hff, v);
    cpu.access(1'b0, 16'h0100, 8'h00, v, e);
    check("unmapped err", 8'h01, {7'h00, e});
    cpu.wr(ARRAY_CONTROL_IDX, 8'h01);
    cpu.wr(ARRAY_CONTROL_IDX, 8'h03);
    cpu.rd(ARRAY_CONTROL_IDX, v);
    check("both bits refused", 8'h01, v);
    cpu.wr(ARRAY_CONTROL_IDX, 8'h09);
    cpu.rd(ARRAY_CONTROL_IDX, v);
    check("high_voltage_enable early", 8'h01, v);
    cpu.wr(ARRAY_CONTROL_IDX, 8'h00);
    cpu.programByte(16'hc001, 8'h5a, 16'hc001, v, fin);
    check("prog high_voltage_enable", 8'h09, v);
    check("prog fail", 8'h00, fin);
    cpu.rd(16'hc001, v);
    check("prog data", 8'h5a, v);
    cpu.programByte(16'hc040, 8'h33, 16'hc040, v, fin);
    cpu.programByte(16'hc002, 8'h0f, 16'hc022, v, fin);
    check("row fault", 8'h80, fin);
    cpu.rd(16'hc022, v);
    check("other row", 8'hff, v);
    cpu.rd(16'hc002, v);
    check("own row", 8'h0f, v);
    cpu.eraseOp(1'b0, 16'hc010, v);
    check("page hv", 8'h8a, v);
    cpu.rd(16'hc001, v);
    check("page erased", 8'hff, v);
    cpu.rd(16'hc040, v);
    check("next page kept", 8'h33, v);
    cpu.programByte(PROTECT_START_IDX, 8'hfd, PROTECT_START_IDX, v, fin);
    check("protect prog", 8'h09, v);
    cpu.programByte(16'hff40, 8'h00, 16'hff40, v, fin);
    check("protected start", 8'h01, v);
    cpu.programByte(16'hff3f, 8'h00, 16'hff3f, v, fin);
    check("below start", 8'h09, v);
    cpu.programByte(PROTECT_START_IDX, 8'h00, PROTECT_START_IDX, v, fin);
    check("protect locked", 8'h01, v);
    cpu.eraseOp(1'b1, 16'hc000, v);
    check("mass blocked", 8'h06, v);
    testHighVoltage <= 1'b1;
    cpu.programByte(PROTECT_START_IDX, 8'h00, PROTECT_START_IDX, v, fin);
    check("bypass prog", 8'h09, v);
    testHighVoltage <= 1'b0;
    cpu.programByte(16'hc100, 8'h00, 16'hc100, v, fin);
    check("zeros protect all", 8'h01, v);
    testHighVoltage <= 1'b1;
    cpu.eraseOp(1'b1, 16'hc000, v);
    check("bypass mass", 8'h0e, v);
    testHighVoltage <= 1'b0;
    cpu.rd(PROTECT_START_IDX, v);
    check("protect erased again", 8'hff, v);
    cpu.rd(16'hff3f, v);
    check("mass whole array", 8'hff, v);
    cpu.rd(16'hc002, v);
    check("mass low page", 8'hff, v);
    check("hv off", 8'h00, {7'h00, highVoltageOn});
    check("hv seen on", 8'h01, {7'h00, hvWasOn});
    summarize();
  end
endmodule
`default_nettype wire
